// ===== design/syp_pkg.sv
// syp_pkg: constants and types for the synchronous serial port
`default_nettype none
package syp_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [3:0] MIN_BITS_M1 = 4'h3;
    localparam logic [3:0] SVC_LEVEL = 4'h4;
    localparam logic [6:0] TIMEOUT_HALVES = 7'h40;
    localparam logic [4:0] MSG_CTRL_PER = 5'h08;
    localparam logic [4:0] MSG_RESP_PER = 5'h09;
    localparam logic [3:0] MSG_CTRL_MSB = 4'h7;
    localparam int unsigned IRQ_TX = 0;
    localparam int unsigned IRQ_RX = 1;
    localparam int unsigned IRQ_OVR = 2;
    localparam int unsigned IRQ_TMO = 3;
    typedef enum logic [1:0] {
        SYP_FMT_SPI = 2'b00,
        SYP_FMT_PULSE = 2'b01,
        SYP_FMT_MSG = 2'b10
    } syp_fmt_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_GAP = 2'b10
    } syp_state_e;
endpackage : syp_pkg
`default_nettype wire

// ===== design/syp_port.sv
// syp_port: serial port engine with its fifo
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------
module syp_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    import syp_pkg::*;
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } syp_fifo_s;
    syp_fifo_s r;
    syp_fifo_s n;
    logic push;
    logic pop;

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad
        $error("fifo depth must be a power of two, at least 2");
    end

    // full refuses the push, so queued words are never touched
    assign in_ready = (r.cnt != CW'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign count = r.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + CW'(push) - CW'(pop);
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    property p_full_keep;
        @(posedge mclk) disable iff (rst)
        in_valid && !in_ready && !out_ready |=> r.cnt == $past(r.cnt);
    endproperty
    a_full_keep: assert property (p_full_keep)
        else $error("push into full fifo changed its fill");

    property p_cnt_bound;
        @(posedge mclk) disable iff (rst)
        push && !pop |=> r.cnt == $past(r.cnt) + 1'b1 && r.cnt <= DEPTH;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("fifo fill count wrong after push");
endmodule : syp_fifo

// ----------------------------------------------------------------
// serial port
// ----------------------------------------------------------------
module syp_port #(
    parameter int unsigned DATA_W = syp_pkg::DATA_W,
    parameter int unsigned FIFO_DEPTH = syp_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic slave_mode,
    input wire syp_pkg::syp_fmt_e frame_format,
    input wire logic clk_polarity,
    input wire logic clk_phase,
    input wire logic [3:0] data_bits_m1,
    input wire logic [7:0] prescale_divisor_reg,
    input wire logic [7:0] serial_rate_div,
    input wire logic [3:0] irq_mask,
    input wire logic overrun_clear,
    input wire logic tx_wr_valid,
    input wire logic [DATA_W-1:0] tx_wr_data,
    output logic tx_wr_ready,
    output logic rx_rd_valid,
    output logic [DATA_W-1:0] rx_rd_data,
    input wire logic rx_rd_ready,
    output logic serial_clock_out,
    input wire logic serial_clock_in,
    output logic frame_select_out,
    input wire logic frame_select_in,
    output logic serial_tx_line,
    input wire logic serial_rx_line,
    output logic busy,
    output logic tx_service_irq,
    output logic rx_service_irq,
    output logic rx_overrun_irq,
    output logic rx_timeout_irq,
    output logic combined_irq,
    output logic tx_dma_req,
    output logic rx_dma_req
);
    import syp_pkg::*;
    localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);

    if (DATA_W != 16 || FIFO_DEPTH < 2) begin : g_bad
        $error("port needs 16-bit words and a fifo of 2 or more");
    end

    typedef struct packed {
        syp_state_e st;
        logic [6:0] pre_cnt;
        logic [7:0] div_cnt;
        logic half;
        logic [4:0] per;
        logic tx_started;
        logic [15:0] tx_sr;
        logic [15:0] rx_sr;
        logic rxd;
        logic rx_push;
        logic take;
        logic push_pend;
        logic [2:0] sck_s;
        logic [1:0] fs_s;
        logic sclk;
        logic fss;
        logic ovr;
        logic [6:0] tmo;
    } syp_core_s;
    syp_core_s r;
    syp_core_s n;

    // mask covering the programmed word length
    function automatic logic [15:0] width_mask(input logic [3:0] m1);
        width_mask = 16'hFFFF >> (4'hF - m1);
    endfunction : width_mask

    logic mst;
    logic [3:0] nb_m1;
    logic [4:0] nbits;
    logic pre;
    logic [4:0] nper;
    logic eff_cpol;
    logic eff_cpha;
    logic [6:0] cpsr_half;
    logic pre_tick;
    logic half_tick;
    logic sck_rise;
    logic sck_fall;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic drive_ev;
    logic tx_win;
    logic rx_win;
    logic [3:0] out_idx;
    logic start_ok;
    logic tx_pop;
    logic rx_pop;
    logic tx_out_valid;
    logic [15:0] tx_out_data;
    logic rx_in_ready;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] rx_cnt;
    logic tx_msb;
    logic [3:0] raw_irq;

    // format decode; spi alone honours polarity and phase
    assign mst = !slave_mode;
    assign nb_m1 = (data_bits_m1 < MIN_BITS_M1) ? MIN_BITS_M1
                                                : data_bits_m1;
    assign nbits = {1'b0, nb_m1} + 5'h01;
    assign pre = mst && (frame_format == SYP_FMT_PULSE);
    assign nper = (frame_format == SYP_FMT_MSG) ? nbits + MSG_RESP_PER
                                                : nbits + {4'h0, pre};
    assign eff_cpol = (frame_format == SYP_FMT_SPI) && clk_polarity;
    assign eff_cpha = (frame_format == SYP_FMT_PULSE) ||
                      ((frame_format == SYP_FMT_SPI) && clk_phase);

    // prescaler feeds second divider; each tick is half a bit period
    assign cpsr_half = (prescale_divisor_reg[7:1] == 7'h00) ? 7'h01
                     : prescale_divisor_reg[7:1];
    assign pre_tick = (r.pre_cnt == 7'h00);
    assign half_tick = pre_tick && (r.div_cnt == 8'h00);

    // slave edges seen after the synchroniser and delay stage
    assign sck_rise = r.sck_s[1] && !r.sck_s[2];
    assign sck_fall = !r.sck_s[1] && r.sck_s[2];

    // leading and trailing edges from own divider or from master
    always_comb begin
        if (mst) begin
            lead_ev = half_tick && (r.st == ST_RUN) && !r.half;
            trail_ev = half_tick && (r.st == ST_RUN) && r.half;
        end else begin
            lead_ev = eff_cpol ? sck_fall : sck_rise;
            trail_ev = eff_cpol ? sck_rise : sck_fall;
        end
    end
    assign sample_ev = eff_cpha ? trail_ev : lead_ev;
    assign drive_ev = eff_cpha ? lead_ev : trail_ev;

    // message format: control byte one way, answer the other way
    always_comb begin
        if (frame_format == SYP_FMT_MSG) begin
            tx_win = mst ? (r.per < MSG_CTRL_PER)
                         : (r.per >= MSG_RESP_PER);
            rx_win = mst ? (r.per >= MSG_RESP_PER)
                         : (r.per < MSG_CTRL_PER);
        end else begin
            tx_win = (r.per >= {4'h0, pre});
            rx_win = tx_win;
        end
    end
    assign out_idx = ((frame_format == SYP_FMT_MSG) && mst)
                   ? MSG_CTRL_MSB : nb_m1;

    // master waits for data and a tick; slave waits for its frame
    always_comb begin
        if (mst) begin
            start_ok = tx_out_valid && half_tick;
        end else if (frame_format == SYP_FMT_PULSE) begin
            start_ok = trail_ev && r.fs_s[1];
        end else begin
            start_ok = !r.fs_s[1];
        end
    end

    // next state of the whole engine
    always_comb begin
        n = r;
        tx_pop = 1'b0;
        // rx line is registered, so each bit shifts in a cycle after
        // its edge; the push waits one more cycle for that last shift
        n.take = 1'b0;
        n.push_pend = 1'b0;
        n.rx_push = r.push_pend;
        n.rxd = serial_rx_line;
        if (r.take) begin
            n.rx_sr = {r.rx_sr[14:0], r.rxd};
        end
        n.sck_s = {r.sck_s[1:0], serial_clock_in};
        n.fs_s = {r.fs_s[0], frame_select_in};
        n.pre_cnt = pre_tick ? cpsr_half - 7'h01 : r.pre_cnt - 7'h01;
        if (pre_tick) begin
            n.div_cnt = (r.div_cnt == 8'h00) ? serial_rate_div
                                             : r.div_cnt - 8'h01;
        end
        case (r.st)
            ST_IDLE: begin
                if (enable && start_ok) begin
                    n.st = ST_RUN;
                    n.per = 5'h00;
                    n.half = 1'b0;
                    n.tx_started = 1'b0;
                    // empty queue in slave mode sends zeros
                    n.tx_sr = tx_out_valid ? tx_out_data : 16'h0000;
                    tx_pop = tx_out_valid;
                end
            end
            ST_RUN: begin
                if (!mst && frame_format != SYP_FMT_PULSE && r.fs_s[1]) begin
                    n.st = ST_IDLE;
                end else begin
                    if (lead_ev) begin
                        n.half = 1'b1;
                    end
                    if (trail_ev) begin
                        n.half = 1'b0;
                    end
                    if (sample_ev && rx_win) begin
                        n.take = 1'b1;
                    end
                    // phase 1 holds the first bit over the first edge
                    if (drive_ev && tx_win) begin
                        n.tx_started = 1'b1;
                        if (!eff_cpha || r.tx_started) begin
                            n.tx_sr = {r.tx_sr[14:0], 1'b0};
                        end
                    end
                    if (trail_ev) begin
                        n.per = r.per + 5'h01;
                        if (r.per + 5'h01 == nper) begin
                            n.st = mst ? ST_GAP : ST_IDLE;
                            n.push_pend = 1'b1;
                        end
                    end
                end
            end
            ST_GAP: begin
                if (half_tick) begin
                    n.st = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        // a new overrun wins over a clear in the same cycle
        if (r.rx_push && !rx_in_ready) begin
            n.ovr = 1'b1;
        end else if (overrun_clear) begin
            n.ovr = 1'b0;
        end
        // idle time counted in half periods while data waits
        if (n.st != ST_IDLE || !rx_rd_valid || rx_pop) begin
            n.tmo = 7'h00;
        end else if (half_tick && r.tmo != TIMEOUT_HALVES) begin
            n.tmo = r.tmo + 7'h01;
        end
        n.sclk = (n.st == ST_RUN && mst) ? (eff_cpol ^ n.half)
                                         : eff_cpol;
        if (frame_format == SYP_FMT_PULSE) begin
            n.fss = (n.st == ST_RUN) && mst && (n.per < {4'h0, pre});
        end else begin
            n.fss = !((n.st == ST_RUN) && mst);
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.sck_s <= 3'h0;
            r.fs_s <= 2'h3;
            r.fss <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // transmit queue; software sees ready low while full
    syp_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(tx_wr_valid),
        .in_data(tx_wr_data),
        .in_ready(tx_wr_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(tx_pop),
        .count(tx_cnt)
    );

    // receive queue; a push into a full queue is dropped
    syp_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(r.rx_push),
        .in_data(r.rx_sr & width_mask(nb_m1)),
        .in_ready(rx_in_ready),
        .out_valid(rx_rd_valid),
        .out_data(rx_rd_data),
        .out_ready(rx_rd_ready),
        .count(rx_cnt)
    );

    assign rx_pop = rx_rd_valid && rx_rd_ready;
    assign tx_msb = tx_out_data[nb_m1];

    // pin outputs; data line quiet outside its window
    assign serial_clock_out = r.sclk;
    assign frame_select_out = r.fss;
    assign serial_tx_line = (r.st == ST_RUN) && tx_win && r.tx_sr[out_idx];
    assign busy = (r.st != ST_IDLE);

    // service irqs track levels, status irqs kept apart
    assign raw_irq[IRQ_TX] = enable && (tx_cnt <= CW'(SVC_LEVEL));
    assign raw_irq[IRQ_RX] = (rx_cnt >= CW'(SVC_LEVEL));
    assign raw_irq[IRQ_OVR] = r.ovr;
    assign raw_irq[IRQ_TMO] = (r.tmo == TIMEOUT_HALVES) && rx_rd_valid;
    assign tx_service_irq = raw_irq[IRQ_TX] && irq_mask[IRQ_TX];
    assign rx_service_irq = raw_irq[IRQ_RX] && irq_mask[IRQ_RX];
    assign rx_overrun_irq = raw_irq[IRQ_OVR] && irq_mask[IRQ_OVR];
    assign rx_timeout_irq = raw_irq[IRQ_TMO] && irq_mask[IRQ_TMO];
    assign combined_irq = |(raw_irq & irq_mask);

    // dma asks for words while enabled with space, or while data exists
    assign tx_dma_req = enable && tx_wr_ready;
    assign rx_dma_req = rx_rd_valid;

    property p_overrun;
        @(posedge mclk) disable iff (rst)
        r.rx_push && !rx_in_ready |=> rx_overrun_irq == irq_mask[IRQ_OVR];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not raised for dropped word");

    property p_sclk_idle;
        @(posedge mclk) disable iff (rst)
        r.st != ST_RUN && $stable(frame_format) && $stable(clk_polarity)
            |-> serial_clock_out == eff_cpol;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock moved while idle");

    property p_select_low;
        @(posedge mclk) disable iff (rst)
        r.st == ST_RUN && mst && frame_format == SYP_FMT_SPI
            |-> !frame_select_out;
    endproperty
    a_select_low: assert property (p_select_low)
        else $error("spi select not low during frame");

    property p_slave_edge;
        @(posedge mclk) disable iff (rst)
        !mst && $rose(serial_clock_in) ##1 serial_clock_in
            |-> ##1 sck_rise;
    endproperty
    a_slave_edge: assert property (p_slave_edge)
        else $error("slave clock edge not seen after three cycles");

    property p_rx_reg;
        @(posedge mclk) disable iff (rst)
        r.take |=> r.rx_sr[0] == $past(r.rxd);
    endproperty
    a_rx_reg: assert property (p_rx_reg)
        else $error("received bit not taken from registered line");

    property p_msb_first;
        @(posedge mclk) disable iff (rst)
        r.st == ST_IDLE && n.st == ST_RUN && mst &&
            frame_format == SYP_FMT_SPI |=> serial_tx_line == $past(tx_msb);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit on line is not the word msb");

    property p_timeout;
        @(posedge mclk) disable iff (rst)
        raw_irq[IRQ_TMO] |-> r.st == ST_IDLE && rx_cnt != '0;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout raised without idle held data");

    property p_half_period;
        @(posedge mclk) disable iff (rst)
        mst && lead_ev && prescale_divisor_reg == 8'h02 &&
            serial_rate_div == 8'h00 |=> trail_ev;
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("fastest divide did not give one-cycle halves");
endmodule : syp_port
`default_nettype wire

// ===== tb/syp_peer.sv
// syp_peer: mode-0 serial slave model on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module syp_peer (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    output logic got_valid,
    output logic [20:0] got
);
    logic [15:0] resp = 16'hc3a5;
    logic [15:0] outr = 16'h0000;
    logic [15:0] shin = 16'h0000;
    logic [4:0] nb = 5'h00;
    logic hold = 1'b0;
    initial got_valid = 1'b0;
    // select low opens a frame and loads the next reply word
    always @(negedge sel_n) begin
        nb = 5'h00;
        shin = 16'h0000;
        outr = resp;
        got_valid = 1'b0;
    end
    // leading edge samples, trailing edge moves on a bit
    always @(posedge sclk) begin
        if (!sel_n) begin
            shin = {shin[14:0], mosi};
            nb = nb + 5'h01;
        end
    end
    always @(negedge sclk) begin
        if (!sel_n)
            outr = {outr[14:0], 1'b0};
    end
    // report only real frames; the x-to-1 at power up is not one
    always @(posedge sel_n) begin
        if (nb != 5'h00) begin
            hold = outr[15];
            got = {nb, shin};
            got_valid = 1'b1;
            resp = resp + 16'h0123;
        end
    end
    // released line flips so a stale bit cannot pass for data
    assign miso = sel_n ? ~hold : outr[15];
endmodule : syp_peer
`default_nettype wire

// ===== tb/syp_port_tb.sv
// syp_port_tb: self-checking bench for the serial port as master and as slave
`timescale 1ns/10ps
`default_nettype none
module syp_port_tb;
    import syp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b0;
    logic slave_mode = 1'b0;
    syp_fmt_e frame_format = SYP_FMT_SPI;
    logic clk_polarity = 1'b0;
    logic clk_phase = 1'b0;
    logic [3:0] bits_m1 = 4'h7;
    logic [7:0] presc = 8'h02;
    logic [7:0] rate = 8'h00;
    logic [3:0] irq_mask = 4'h0;
    logic overrun_clear = 1'b0;
    logic tx_wr_valid = 1'b0;
    logic [15:0] tx_wr_data = 16'h0000;
    logic rx_rd_ready = 1'b1;
    logic sclk_in = 1'b0;
    logic sel_in = 1'b1;
    logic tx_wr_ready, rx_rd_valid, sclk, sel, txl, rxl, busy, got_valid;
    logic irq_tx, irq_rx, irq_ovr, irq_tmo, irq_all, dma_tx, dma_rx;
    logic [15:0] rx_rd_data;
    logic [20:0] got;
    logic [31:0] lfsr = 32'h0001_6193;
    logic [15:0] resp_m = 16'hc3a5;
    logic [15:0] mask = 16'h00ff;
    logic [4:0] nbits = 5'h08;
    logic [19:0] cfgs [4] = '{20'h3_0200, 20'hb_fe00, 20'hf_02ff,
        20'h0_0101};
    logic [20:0] tx_q[$];
    logic [15:0] rx_q[$];
    int fail_count = 0;
    int comparisons = 0;
    int half = 1;
    int hi = 0;
    int rx_room = 99;
    int w = 0;

    always #5 mclk = ~mclk; // one clock for bus and reference

    syp_port u_dut (.mclk(mclk), .rst(rst), .enable(enable),
        .slave_mode(slave_mode), .frame_format(frame_format),
        .clk_polarity(clk_polarity), .clk_phase(clk_phase),
        .data_bits_m1(bits_m1), .prescale_divisor_reg(presc),
        .serial_rate_div(rate), .irq_mask(irq_mask),
        .overrun_clear(overrun_clear), .tx_wr_valid(tx_wr_valid),
        .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready),
        .rx_rd_valid(rx_rd_valid), .rx_rd_data(rx_rd_data),
        .rx_rd_ready(rx_rd_ready), .serial_clock_out(sclk),
        .serial_clock_in(sclk_in), .frame_select_out(sel),
        .frame_select_in(sel_in), .serial_tx_line(txl),
        .serial_rx_line(rxl), .busy(busy), .tx_service_irq(irq_tx),
        .rx_service_irq(irq_rx), .rx_overrun_irq(irq_ovr),
        .rx_timeout_irq(irq_tmo), .combined_irq(irq_all),
        .tx_dma_req(dma_tx), .rx_dma_req(dma_rx));
    syp_peer u_peer (.sclk(sclk), .sel_n(sel), .mosi(txl), .miso(rxl),
        .got_valid(got_valid), .got(got));

    task automatic check(input logic [31:0] e, input logic [31:0] a);
        comparisons++;
        if (a !== e) begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : check

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // only while idle: the port wants config steady across a frame
    task automatic cfg(input logic [3:0] b, input logic [7:0] p,
            input logic [7:0] r);
        bits_m1 <= b;
        presc <= p;
        rate <= r;
        nbits = (b < 4'h3) ? 5'h04 : 5'(b) + 5'h01;
        mask = 16'hffff >> (16 - nbits);
        half = ((p[7:1] == 7'h00) ? 1 : int'(p[7:1])) * (int'(r) + 1);
        @(posedge mclk);
    endtask : cfg

    // valid held high across words, so no double drive in one step
    task automatic burst(input int cnt, input int acc);
        for (int i = 0; i < cnt; i++) begin
            lfsr = lfsr_next(lfsr);
            tx_wr_valid <= 1'b1;
            tx_wr_data <= lfsr[15:0];
            @(posedge mclk);
            check(32'(i < acc), 32'(tx_wr_ready));
            if (i < acc) begin
                tx_q.push_back({nbits, lfsr[15:0] & mask});
                if (rx_room > 0)
                    rx_q.push_back(resp_m >> (16 - nbits));
                rx_room--;
                resp_m = resp_m + 16'h0123;
            end
        end
        tx_wr_valid <= 1'b0;
    endtask : burst

    task automatic wait_tx;
        w = 0;
        while ((tx_q.size() != 0 || busy !== 1'b0) && w < 30000) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 30000)
            check(32'h0, 32'h1);
        repeat (2) @(posedge mclk);
    endtask : wait_tx

    task automatic wrap_up;
        $display("counts: comparisons=%0d fail_count=%0d", comparisons,
            fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // word seen by the far side against the oldest written word
    always @(posedge got_valid) begin
        if (tx_q.size() == 0)
            check(32'hffff_ffff, 32'(got));
        else
            check(32'(tx_q.pop_front()), 32'(got));
    end

    // word read back against the oldest reply still expected
    always @(posedge mclk) begin
        if (rx_rd_valid === 1'b1 && rx_rd_ready) begin
            if (rx_q.size() == 0)
                check(32'hffff_ffff, 32'(rx_rd_data));
            else
                check(32'(rx_q.pop_front()), 32'(rx_rd_data));
        end
    end

    // clock high time per bit, and no clock outside a selected frame
    always @(posedge mclk) begin
        if (sclk === 1'b1) begin
            hi++;
            if (sel !== 1'b0)
                check(32'h0, 32'h1);
        end else if (hi != 0) begin
            check(32'(half), 32'(hi));
            hi = 0;
        end
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check(32'h50, 32'({tx_wr_ready, rx_rd_valid, sel, sclk, txl, busy,
            irq_all}));
        // fill while disabled: ninth word bounces, nothing moves
        irq_mask <= 4'h1;
        cfg(4'h7, 8'h05, 8'h01);
        burst(9, 8);
        check(32'h0, 32'({irq_tx, dma_tx, busy, sclk}));
        enable <= 1'b1;
        wait_tx();
        $display("test fill and stream done");
        // word length and divider corners
        for (int i = 0; i < 4; i++) begin
            cfg(cfgs[i][19:16], cfgs[i][15:8], cfgs[i][7:0]);
            burst(2, 2);
            wait_tx();
        end
        $display("test lengths and rates done");
        // receive left unread: eight kept, ninth dropped
        cfg(4'h7, 8'h02, 8'h00);
        rx_rd_ready <= 1'b0;
        irq_mask <= 4'hb;
        rx_room = 8;
        burst(8, 8);
        wait_tx();
        burst(1, 1);
        wait_tx();
        check(32'h6, 32'({irq_rx, dma_rx, irq_ovr}));
        w = 0;
        while (irq_tmo !== 1'b1 && w < 200) begin
            @(posedge mclk);
            w++;
        end
        check(32'h1, 32'(irq_tmo));
        irq_mask <= 4'hf;
        repeat (2) @(posedge mclk);
        check(32'h3f, 32'({irq_tx, irq_rx, irq_ovr, irq_tmo, irq_all,
            dma_tx}));
        overrun_clear <= 1'b1;
        @(posedge mclk);
        overrun_clear <= 1'b0;
        repeat (2) @(posedge mclk);
        check(32'h1, 32'({irq_ovr, irq_all}));
        irq_mask <= 4'h0;
        repeat (2) @(posedge mclk);
        check(32'h0, 32'(irq_all));
        irq_mask <= 4'hf;
        rx_rd_ready <= 1'b1;
        rx_room = 99;
        repeat (12) @(posedge mclk);
        check(32'h0, 32'({irq_rx, irq_tmo, dma_rx,
            rx_q.size() != 0}));
        $display("test overrun and irqs done");
        // slave: bench plays master, 4-bit word, slow clock on the pin
        cfg(4'h3, 8'h02, 8'h00);
        slave_mode <= 1'b1;
        lfsr = lfsr_next(lfsr);
        tx_wr_valid <= 1'b1;
        tx_wr_data <= lfsr[15:0];
        @(posedge mclk);
        tx_wr_valid <= 1'b0;
        sel_in <= 1'b0;
        repeat (8) @(posedge mclk);
        // far side is deselected, so its line holds one level
        rx_q.push_back({12'h000, {4{rxl}}});
        for (int i = 3; i >= 0; i--) begin
            check(32'(lfsr[i]), 32'(txl));
            sclk_in <= 1'b1;
            repeat (8) @(posedge mclk);
            sclk_in <= 1'b0;
            repeat (8) @(posedge mclk);
        end
        sel_in <= 1'b1;
        repeat (8) @(posedge mclk);
        check(32'h0, 32'({busy, rx_q.size() != 0}));
        $display("test slave done");
        wrap_up();
    end

    // watchdog: the tests need roughly twenty-five thousand cycles
    initial begin
        repeat (80000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end
endmodule : syp_port_tb
`default_nettype wire
